// file: xops_map.svh
/*
  constant map for the memory shift, exchange and block operation unit.
  assumes inclusion by the package and the bench only.
*/
`ifndef XOPS_MAP_SVH
`define XOPS_MAP_SVH
// ==========================================================
// prefixes and opcodes
`define PFX_BIT        8'hCB
`define PFX_EXT        8'hED
`define PFX_IDX1       8'hDD
`define PFX_IDX2       8'hFD
`define OP_RRC_M       8'h0E
`define OP_RR_M        8'h1E
`define OP_SLA_M       8'h26
`define OP_SRA_M       8'h2E
`define OP_SRL_M       8'h3E
`define OP_RLD         8'h6F
`define OP_RRD         8'h67
`define OP_EX_PTR      8'hEB
`define OP_EX_AF       8'h08
`define OP_EXX         8'hD9
`define OP_EX_SP       8'hE3
`define OP_LDI         8'hA0
`define OP_LDD         8'hA8
`define OP_CPI         8'hA1
`define OP_CPD         8'hA9
`define OP_BLOCK_MOVE_UP_REPEAT        8'hB0
`define OP_BLOCK_MOVE_DOWN_REPEAT        8'hB8
`define OP_BLOCK_COMPARE_UP_REPEAT        8'hB1
// ==========================================================
// flag bit positions
`define FL_C           0
`define FL_N           1
`define FL_PV          2
`define FL_H           4
`define FL_Z           6
`define FL_S           7
// ==========================================================
// apb map (byte addresses)
`define A_CTRL         8'h00
`define A_OPC          8'h04
`define A_DISP         8'h08
`define A_AF           8'h0C
`define A_BC           8'h10
`define A_DE           8'h14
`define A_HL           8'h18
`define A_SP           8'h1C
`define A_IDX1         8'h20
`define A_IDX2         8'h24
`define A_ALT          8'h28
`define A_STAT         8'h2C
`define A_TCNT         8'h30
`define A_MDAT         8'h34
`define A_MAX          8'h34
// ==========================================================
// ctrl bits, memory depth, repeat state counts and constants
`define C_START        0
`define MEM_AW         16
`define ONE16          16'h0001
`define T_REP_MID      5'd21
`define T_REP_END      5'd16
`define ZERO8          8'h00
`endif

// file: xops_pkg.sv
/*
  types for the memory shift, exchange and block operation unit.
  assumes xops_map.svh is on the include path.
*/
package xops_pkg;
  `include "xops_map.svh"
  typedef enum logic [3:0] {
    OPK_NONE  = 4'b0000,
    OPK_SHM   = 4'b0001,
    OPK_NIB   = 4'b0010,
    OPK_EXPTR = 4'b0011,
    OPK_EXAF  = 4'b0100,
    OPK_EXX   = 4'b0101,
    OPK_EXSP  = 4'b0110,
    OPK_MOVE  = 4'b0111,
    OPK_CMP   = 4'b1000
  } op_kind_e;
  typedef struct packed {
    op_kind_e    kind;
    logic        indexed;
    logic        idx_sel;
    logic        down;
    logic        repeat_op;
    logic [7:0]  sub;
    logic [4:0]  tstates;
    logic        valid;
  } dec_s;
  typedef struct packed {
    logic [7:0]  res;
    logic [7:0]  flags;
  } alu_s;
endpackage : xops_pkg

// file: xops_decode.sv
/*
  decodes an opcode string, prefixed or not, into an operation and its state count.
  assumes bytes arrive already assembled in issue order.
*/
`timescale 1ns/1ns
module xops_decode (
  input  wire logic [7:0]      op0,
  input  wire logic [7:0]      op1,
  input  wire logic [7:0]      op3,
  output xops_pkg::dec_s       dec
);
  import xops_pkg::*;
  // ==========================================================
  // decode
  always_comb begin
    dec = '0;
    dec.kind = OPK_NONE;
    if ((op0 == `PFX_IDX1 || op0 == `PFX_IDX2) && op1 == `PFX_BIT) begin // [RULE25]
      dec.kind = OPK_SHM;
      dec.indexed = 1'b1;
      dec.idx_sel = (op0 == `PFX_IDX2);
      dec.sub = op3;
      dec.tstates = 5'd23; // [RULE2]
      dec.valid = (op3 == `OP_RRC_M) || (op3 == `OP_RR_M) || (op3 == `OP_SLA_M)
                  || (op3 == `OP_SRA_M) || (op3 == `OP_SRL_M);
    end else if ((op0 == `PFX_IDX1 || op0 == `PFX_IDX2) && op1 == `OP_EX_SP) begin
      dec.kind = OPK_EXSP;
      dec.indexed = 1'b1;
      dec.idx_sel = (op0 == `PFX_IDX2);
      dec.tstates = 5'd23; // [RULE13]
      dec.valid = 1'b1;
    end else if (op0 == `PFX_BIT) begin
      dec.kind = OPK_SHM;
      dec.sub = op1;
      dec.tstates = 5'd15; // [RULE1]
      dec.valid = (op1 == `OP_RRC_M) || (op1 == `OP_RR_M) || (op1 == `OP_SLA_M)
                  || (op1 == `OP_SRA_M) || (op1 == `OP_SRL_M);
    end else if (op0 == `PFX_EXT) begin
      dec.sub = op1;
      dec.valid = 1'b1;
      dec.tstates = 5'd16; // [RULE15]
      case (op1)
        `OP_RLD, `OP_RRD: begin
          dec.kind = OPK_NIB; // [RULE7]
          dec.tstates = 5'd18;
        end
        `OP_LDI:  dec.kind = OPK_MOVE;
        `OP_LDD:  begin
          dec.kind = OPK_MOVE;
          dec.down = 1'b1;
        end
        `OP_CPI:  dec.kind = OPK_CMP;
        `OP_CPD:  begin
          dec.kind = OPK_CMP;
          dec.down = 1'b1;
        end
        `OP_BLOCK_MOVE_UP_REPEAT: begin
          dec.kind = OPK_MOVE; // [RULE20]
          dec.repeat_op = 1'b1;
        end
        `OP_BLOCK_MOVE_DOWN_REPEAT: begin
          dec.kind = OPK_MOVE;
          dec.down = 1'b1;
          dec.repeat_op = 1'b1;
        end
        `OP_BLOCK_COMPARE_UP_REPEAT: begin
          dec.kind = OPK_CMP;
          dec.repeat_op = 1'b1;
        end
        default: dec.valid = 1'b0;
      endcase
    end else begin
      dec.valid = 1'b1;
      dec.tstates = 5'd4;
      case (op0)
        `OP_EX_PTR: dec.kind = OPK_EXPTR; // [RULE8]
        `OP_EX_AF:  dec.kind = OPK_EXAF;  // [RULE9]
        `OP_EXX:    dec.kind = OPK_EXX;   // [RULE10]
        `OP_EX_SP:  begin
          dec.kind = OPK_EXSP;
          dec.tstates = 5'd19; // [RULE12]
        end
        default: dec.valid = 1'b0;
      endcase
    end
  end
endmodule : xops_decode

// file: xops_alu.sv
/*
  shift, rotate and compare arithmetic with flag results.
  assumes a one-hot choice of operation from the caller.
*/
`timescale 1ns/1ns
module xops_alu (
  input  wire logic [7:0]      sub,
  input  wire logic [7:0]      opnd,
  input  wire logic [7:0]      acc,
  input  wire logic [7:0]      fin,
  input  wire logic            cmp,
  input  wire logic            cnt_nz,
  output xops_pkg::alu_s       out
);
  import xops_pkg::*;
  function automatic logic even_par(input logic [7:0] v);
    even_par = ~^v;
  endfunction : even_par
  logic [8:0] diff;
  logic [4:0] ldiff;
  // ==========================================================
  // datapath
  always_comb begin
    diff = {1'b0, acc} - {1'b0, opnd};
    ldiff = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]};
    out.res = opnd;
    out.flags = fin;
    if (cmp) begin
      out.flags[`FL_S] = diff[7];
      out.flags[`FL_Z] = (acc == opnd); // [RULE17]
      out.flags[`FL_H] = ldiff[4]; // [RULE18]
      out.flags[`FL_PV] = cnt_nz; // [RULE18]
      out.flags[`FL_N] = 1'b1; // [RULE16]
    end else begin
      case (sub)
        `OP_RRC_M: out.res = {opnd[0], opnd[7:1]}; // [RULE3]
        `OP_RR_M:  out.res = {fin[`FL_C], opnd[7:1]}; // [RULE4]
        `OP_SLA_M: out.res = {opnd[6:0], 1'b0};
        `OP_SRA_M: out.res = {opnd[7], opnd[7:1]}; // [RULE5]
        `OP_SRL_M: out.res = {1'b0, opnd[7:1]}; // [RULE6]
        default:   out.res = opnd;
      endcase
      out.flags[`FL_C] = (sub == `OP_SLA_M) ? opnd[7] : opnd[0];
      out.flags[`FL_S] = out.res[7];
      out.flags[`FL_Z] = (out.res == `ZERO8);
      out.flags[`FL_H] = 1'b0;
      out.flags[`FL_N] = 1'b0;
      out.flags[`FL_PV] = even_par(out.res);
    end
  end
endmodule : xops_alu

// file: xops_unit.sv
/*
  execution unit for memory shifts, nibble rotates, exchanges and block ops.
  holds its own 64k byte memory; software loads opcode bytes and registers
  over apb, sets start, and polls busy. assumes a well-behaved apb master.
*/
// The register addresses and the APB interface to the registers were decided locally.
// Contract
// [RULE1] indirect memory shift: 15 states
// [RULE2] indexed memory shift: 23 states
// [RULE3] circular right rotate: carry from bit0
// [RULE4] rotate through carry: old carry into bit7
// [RULE5] arithmetic right shift keeps bit7
// [RULE6] logical right shift inserts zero
// [RULE7] nibble rotates between accumulator and memory
// [RULE8] pointer pair swap: four states, no flags
// [RULE9] accumulator/flag swap with alternates
// [RULE10] bulk swap of three pairs
// [RULE11] stack swap low/high bytes with pair
// [RULE12] stack swap pointer pair: 19 states
// [RULE13] stack swap index register: 23 states
// [RULE14] move up: copy, step, count, flags
// [RULE15] move down: 16 states, pointers decrement
// [RULE16] compare up: subtract, step, set N
// [RULE17] compare zero flag means equal
// [RULE18] half from bit4, PV count nonzero
// [RULE19] compare down: same flags
// [RULE20] repeat move up until count zero
// [RULE21] repeat iterations 21 states, last 16
// [RULE22] repeats run as separate iterations
// [RULE23] repeat move down until count zero
// [RULE24] repeat compare stops on zero or match
// [RULE25] indexed order: prefix, bit prefix, disp, op
`timescale 1ns/1ns
module xops_unit (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic                 busy,
  output logic                 iter_pulse
);
  import xops_pkg::*;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } state_e;
  // ==========================================================
  // storage
  logic [7:0]  mem [0:(1<<`MEM_AW)-1];
  logic [31:0] opc_q;
  logic [7:0]  disp_q;
  logic [7:0]  a_q;
  logic [7:0]  f_q;
  logic [7:0]  a2_q;
  logic [7:0]  f2_q;
  logic [15:0] bc_q;
  logic [15:0] de_q;
  logic [15:0] hl_q;
  logic [15:0] sp_q;
  logic [15:0] ix1_q;
  logic [15:0] ix2_q;
  logic [15:0] bc2_q;
  logic [15:0] de2_q;
  logic [15:0] hl2_q;
  logic [15:0] maddr_q;
  logic [4:0]  tcnt_q;
  logic [4:0]  tlast_q;
  logic [15:0] iters_q;
  logic        bad_q;
  state_e      st_q;
  dec_s        dec;
  alu_s        alu;
  logic [15:0] ea;
  logic [7:0]  mval;
  logic [15:0] bc_m1;
  logic        run_go;
  logic        wr_acc;
  logic        rd_acc;
  logic [15:0] step;
  logic        more;
  logic [4:0]  iter_len;
  // ==========================================================
  // decode and arithmetic
  xops_decode u_dec (
    .op0 (opc_q[7:0]),
    .op1 (opc_q[15:8]),
    .op3 (opc_q[31:24]),
    .dec (dec)
  );
  function automatic logic [15:0] add_disp(input logic [15:0] b, input logic [7:0] d);
    add_disp = b + {{8{d[7]}}, d};
  endfunction : add_disp
  assign bc_m1 = bc_q - `ONE16;
  assign ea = !dec.indexed ? hl_q : add_disp(dec.idx_sel ? ix2_q : ix1_q, disp_q); // [RULE25]
  assign mval = mem[ea];
  assign step = dec.down ? 16'hFFFF : `ONE16;
  xops_alu u_alu (
    .sub    (dec.sub),
    .opnd   (mval),
    .acc    (a_q),
    .fin    (f_q),
    .cmp    (dec.kind == OPK_CMP),
    .cnt_nz (bc_m1 != 16'h0000),
    .out    (alu)
  );
  // repeat continues while count nonzero and (for compare) no match
  assign more = dec.repeat_op && (bc_m1 != 16'h0000)
                && !(dec.kind == OPK_CMP && mval == a_q); // [RULE24]
  // ==========================================================
  // apb slave: zero wait, unmapped gets slverr
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign pslverr = psel && penable && (paddr > `A_MAX || paddr[1:0] != 2'b00);
  // a step that repeats carries the extra states; the last one is short
  assign iter_len = more ? `T_REP_MID : tlast_q; // [RULE21]
  assign run_go = (st_q == ST_RUN) && (tcnt_q == iter_len);
  assign busy = (st_q != ST_IDLE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (paddr)
        `A_CTRL: prdata <= {31'h0000_0000, busy};
        `A_OPC:  prdata <= opc_q;
        `A_DISP: prdata <= {24'h00_0000, disp_q};
        `A_AF:   prdata <= {16'h0000, a_q, f_q};
        `A_BC:   prdata <= {16'h0000, bc_q};
        `A_DE:   prdata <= {16'h0000, de_q};
        `A_HL:   prdata <= {16'h0000, hl_q};
        `A_SP:   prdata <= {16'h0000, sp_q};
        `A_IDX1: prdata <= {16'h0000, ix1_q};
        `A_IDX2: prdata <= {16'h0000, ix2_q};
        `A_ALT:  prdata <= {a2_q, f2_q, 16'h0000};
        `A_STAT: prdata <= {iters_q, 14'h0000, bad_q, busy};
        `A_TCNT: prdata <= {27'h000_0000, tlast_q};
        `A_MDAT: prdata <= {16'h0000, 8'h00, mem[maddr_q]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  // ==========================================================
  // sequencer: each iteration counts its own states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      tcnt_q <= 5'd0;
      tlast_q <= 5'd0;
      bad_q <= 1'b0;
      iters_q <= 16'h0000;
      iter_pulse <= 1'b0;
    end else begin
      iter_pulse <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (wr_acc && paddr == `A_CTRL && pwdata[`C_START]) begin
            bad_q <= !dec.valid;
            iters_q <= 16'h0000;
            tcnt_q <= 5'd1;
            tlast_q <= dec.tstates;
            st_q <= dec.valid ? ST_RUN : ST_IDLE;
          end
        end
        ST_RUN: begin
          if (run_go) begin
            iter_pulse <= 1'b1;
            iters_q <= iters_q + `ONE16;
            tcnt_q <= 5'd1;
            if (!more) begin // [RULE22]
              st_q <= ST_DONE;
            end
          end else begin
            tcnt_q <= tcnt_q + 5'd1;
          end
        end
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // apb-loaded control words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opc_q <= 32'h0000_0000;
      disp_q <= 8'h00;
      maddr_q <= 16'h0000;
    end else if (wr_acc && !busy) begin
      if (paddr == `A_OPC) opc_q <= pwdata;
      if (paddr == `A_DISP) disp_q <= pwdata[7:0];
      if (paddr == `A_MDAT) maddr_q <= pwdata[31:16];
    end
  end
  // ==========================================================
  // memory: apb writes byte at maddr, execution writes at iteration end
  always_ff @(posedge pclk) begin
    if (wr_acc && !busy && paddr == `A_MDAT) begin
      mem[pwdata[31:16]] <= pwdata[7:0];
    end else if (run_go) begin
      case (dec.kind)
        OPK_SHM: mem[ea] <= alu.res;
        OPK_NIB: mem[hl_q] <= (dec.sub == `OP_RLD) ? {mval[3:0], a_q[3:0]}
                                                   : {a_q[3:0], mval[7:4]}; // [RULE7]
        OPK_MOVE: mem[de_q] <= mval; // [RULE14]
        OPK_EXSP: begin
          mem[sp_q] <= dec.indexed ? (dec.idx_sel ? ix2_q[7:0] : ix1_q[7:0])
                                   : hl_q[7:0]; // [RULE11]
          mem[sp_q + `ONE16] <= dec.indexed ? (dec.idx_sel ? ix2_q[15:8] : ix1_q[15:8])
                                            : hl_q[15:8];
        end
        default: ;
      endcase
    end
  end
  // ==========================================================
  // register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 8'h00;
      f_q <= 8'h00;
      a2_q <= 8'h00;
      f2_q <= 8'h00;
      bc_q <= 16'h0000;
      de_q <= 16'h0000;
      hl_q <= 16'h0000;
      sp_q <= 16'h0000;
      ix1_q <= 16'h0000;
      ix2_q <= 16'h0000;
      bc2_q <= 16'h0000;
      de2_q <= 16'h0000;
      hl2_q <= 16'h0000;
    end else if (wr_acc && !busy) begin
      case (paddr)
        `A_AF:   {a_q, f_q} <= pwdata[15:0];
        `A_BC:   bc_q <= pwdata[15:0];
        `A_DE:   de_q <= pwdata[15:0];
        `A_HL:   hl_q <= pwdata[15:0];
        `A_SP:   sp_q <= pwdata[15:0];
        `A_IDX1: ix1_q <= pwdata[15:0];
        `A_IDX2: ix2_q <= pwdata[15:0];
        `A_ALT:  {a2_q, f2_q} <= pwdata[31:16];
        default: ;
      endcase
    end else if (run_go) begin
      case (dec.kind)
        OPK_SHM: f_q <= alu.flags;
        OPK_NIB: begin
          a_q <= (dec.sub == `OP_RLD) ? {a_q[7:4], mval[7:4]} : {a_q[7:4], mval[3:0]};
        end
        OPK_EXPTR: begin
          de_q <= hl_q; // [RULE8]
          hl_q <= de_q;
        end
        OPK_EXAF: begin
          a_q <= a2_q; // [RULE9]
          f_q <= f2_q;
          a2_q <= a_q;
          f2_q <= f_q;
        end
        OPK_EXX: begin
          bc_q <= bc2_q; // [RULE10]
          de_q <= de2_q;
          hl_q <= hl2_q;
          bc2_q <= bc_q;
          de2_q <= de_q;
          hl2_q <= hl_q;
        end
        OPK_EXSP: begin
          if (!dec.indexed) hl_q <= {mem[sp_q + `ONE16], mem[sp_q]}; // [RULE11]
          else if (dec.idx_sel) ix2_q <= {mem[sp_q + `ONE16], mem[sp_q]};
          else ix1_q <= {mem[sp_q + `ONE16], mem[sp_q]};
        end
        OPK_MOVE: begin
          hl_q <= hl_q + step; // [RULE14] [RULE15] [RULE23]
          de_q <= de_q + step;
          bc_q <= bc_m1;
          f_q[`FL_H] <= 1'b0;
          f_q[`FL_N] <= 1'b0;
          f_q[`FL_PV] <= (bc_m1 != 16'h0000); // [RULE20]
        end
        OPK_CMP: begin
          hl_q <= hl_q + step; // [RULE16] [RULE19]
          bc_q <= bc_m1;
          f_q <= alu.flags;
        end
        default: ;
      endcase
    end
  end
  // ==========================================================
  // checks
  a_shift_len: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    ($rose(busy) && dec.kind == OPK_SHM && !dec.indexed)
      |-> tlast_q == 5'd15)
    else $error("indirect shift length wrong");
  a_idx_len: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    ($rose(busy) && dec.kind == OPK_SHM && dec.indexed) |-> tlast_q == 5'd23)
    else $error("indexed shift length wrong");
  a_srl_top: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (!(dec.kind == OPK_CMP) && dec.sub == `OP_SRL_M) |-> !alu.res[7] && !alu.flags[`FL_S])
    else $error("logical shift top bit set");
  a_sra_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (dec.kind == OPK_SHM && dec.sub == `OP_SRA_M) |-> alu.res[7] == mval[7])
    else $error("arith shift lost sign");
  a_cmp_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    (run_go && dec.kind == OPK_CMP) |=> f_q[`FL_Z] == ($past(mval) == $past(a_q)))
    else $error("compare zero flag wrong");
  a_move_cnt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    (run_go && dec.kind == OPK_MOVE) |=> bc_q == $past(bc_q) - `ONE16)
    else $error("move count not decremented");
  a_rep_len: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
    (run_go && more) |-> tcnt_q == `T_REP_MID)
    else $error("repeat step length wrong");
  a_last_len: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
    (run_go && dec.repeat_op && !more) |-> tcnt_q == `T_REP_END)
    else $error("final repeat step length wrong");
  a_move_pv: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
    (run_go && dec.kind == OPK_MOVE && dec.repeat_op && !more) |=> !f_q[`FL_PV])
    else $error("repeat move left overflow flag set");
  a_exx_swap: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    (run_go && dec.kind == OPK_EXX) |=> bc_q == $past(bc2_q) && f_q == $past(f_q))
    else $error("bulk swap wrong");
  c_rep: cover property (@(posedge pclk) run_go && more);
  c_idx: cover property (@(posedge pclk) run_go && dec.indexed);
  c_cmp_hit: cover property (@(posedge pclk) run_go && dec.kind == OPK_CMP && mval == a_q);
  c_nib: cover property (@(posedge pclk) run_go && dec.kind == OPK_NIB);
endmodule : xops_unit

// file: apb_host.sv
/*
  apb host model standing in front of the unit: software's side of the bus.
  assumes pclk from the bench; pready is sampled only at rising edges.
*/
`timescale 1ns/1ns
module apb_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // ==========================================================
  // one transfer: setup, access until pready, then release
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_host

// file: memory_shift_exchange_block_ops_bench.sv
/*
  self-checking bench for the shift, exchange and block operation unit.
  assumes xops_pkg, xops_map.svh and apb_host are compiled alongside.
*/
`timescale 1ns/1ns
`include "xops_map.svh"
module memory_shift_exchange_block_ops_bench;
  import xops_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, busy, iter_pulse;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          err_count = 0;
  int          total_checks = 0;
  int          pulses = 0;
  localparam logic [15:0] full = 16'hFFFF;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (iter_pulse === 1'b1) pulses <= pulses + 1;
  xops_unit i_xops_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .iter_pulse(iter_pulse));
  apb_host i_apb_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ==========================================================
  // helpers
  task chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      err_count++;
      $display("ERROR %0t: seen %h want %h", $time, s, x);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    i_apb_host.xfer(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    i_apb_host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd
  task rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] x);
    logic [31:0] q;
    rd(a, q);
    chk({16'h0000, q[15:0] & m}, {16'h0000, x});
  endtask : rc
  task rw(input logic [7:0] a, input logic [15:0] v);
    wr(a, {16'h0000, v});
  endtask : rw
  task mw(input logic [15:0] a, input logic [7:0] d);
    wr(`A_MDAT, {a, 8'h00, d});
  endtask : mw
  // polls busy with a bound; a hang shows as a mismatch
  task go(input logic [31:0] opc, input logic [7:0] dsp);
    logic [31:0] q;
    int          n;
    logic        b;
    wr(`A_OPC, opc);
    wr(`A_DISP, {24'h00_0000, dsp});
    wr(`A_CTRL, 32'h0000_0001);
    @(negedge pclk) b = busy;
    n = 0;
    do begin
      rd(`A_STAT, q);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    if (n >= 100) chk(q, 32'h0000_0000);
    chk({31'h0000_0000, b}, {31'h0000_0000, !q[1]});
  endtask : go
  // ==========================================================
  // scenarios
  task t_shift;
    logic [7:0]  ops [5] = '{`OP_RRC_M, `OP_RR_M, `OP_SRA_M, `OP_SRL_M, `OP_SLA_M};
    logic [15:0] res [5] = '{16'h00C0, 16'h00C0, 16'h00C0, 16'h0040, 16'h0002};
    logic [15:0] fl [5]  = '{16'h0085, 16'h0001, 16'h0085, 16'h0001, 16'h0001};
    logic [15:0] fm [5]  = '{16'h00D7, 16'h0001, 16'h00D7, 16'h00D7, 16'h00D7};
    for (int i = 0; i < 5; i++) begin
      rw(`A_AF, 16'h0001);
      rw(`A_HL, 16'h0200);
      mw(16'h0200, 8'h81);
      go({16'h0000, ops[i], `PFX_BIT}, 8'h00);
      rc(`A_MDAT, full, res[i]);
      rc(`A_AF, fm[i], fl[i]);
      rc(`A_TCNT, full, 16'h000F);
    end
    rw(`A_AF, 16'h1200);
    mw(16'h0200, 8'h34);
    go({16'h0000, `OP_RLD, `PFX_EXT}, 8'h00);
    rc(`A_MDAT, full, 16'h0042);
    rc(`A_AF, 16'hFF00, 16'h1300);
    go({16'h0000, `OP_RRD, `PFX_EXT}, 8'h00);
    rc(`A_MDAT, full, 16'h0034);
    rc(`A_AF, 16'hFF00, 16'h1200);
    $display("test shift done");
  endtask : t_shift
  task t_index;
    for (int j = 0; j < 2; j++) begin
      rw(j ? `A_IDX2 : `A_IDX1, 16'h0302);
      mw(16'h0300, 8'h02);
      go({`OP_SRL_M, 8'hFE, `PFX_BIT, j ? `PFX_IDX2 : `PFX_IDX1}, 8'hFE);
      rc(`A_MDAT, full, 16'h0001);
      rc(`A_TCNT, full, 16'h0017);
    end
    $display("test indexed done");
  endtask : t_index
  task t_exch;
    rw(`A_DE, 16'h1111);
    rw(`A_HL, 16'h2222);
    rw(`A_AF, 16'h3344);
    go({24'h00_0000, `OP_EX_PTR}, 8'h00);
    rc(`A_DE, full, 16'h2222);
    rc(`A_HL, full, 16'h1111);
    rc(`A_AF, full, 16'h3344);
    rc(`A_TCNT, full, 16'h0004);
    wr(`A_ALT, 32'h5566_0000);
    go({24'h00_0000, `OP_EX_AF}, 8'h00);
    rc(`A_AF, full, 16'h5566);
    rw(`A_SP, 16'h0400);
    mw(16'h0401, 8'h12);
    mw(16'h0400, 8'h34);
    rw(`A_HL, 16'hBEEF);
    go({24'h00_0000, `OP_EX_SP}, 8'h00);
    rc(`A_HL, full, 16'h1234);
    rc(`A_MDAT, full, 16'h00EF);
    rc(`A_TCNT, full, 16'h0013);
    go({16'h0000, `OP_EX_SP, `PFX_IDX1}, 8'h00);
    rc(`A_IDX1, full, 16'hBEEF);
    rc(`A_TCNT, full, 16'h0017);
    $display("test exchange done");
  endtask : t_exch
  task t_block;
    rw(`A_BC, 16'h0002);
    rw(`A_HL, 16'h0500);
    rw(`A_DE, 16'h0600);
    rw(`A_AF, 16'h0000);
    mw(16'h0500, 8'h5A);
    mw(16'h0600, 8'h00);
    go({16'h0000, `OP_LDI, `PFX_EXT}, 8'h00);
    rc(`A_MDAT, full, 16'h005A);
    rc(`A_BC, full, 16'h0001);
    rc(`A_HL, full, 16'h0501);
    rc(`A_AF, 16'h0016, 16'h0004);
    go({16'h0000, `OP_LDD, `PFX_EXT}, 8'h00);
    rc(`A_DE, full, 16'h0600);
    rc(`A_BC, full, 16'h0000);
    rc(`A_TCNT, full, 16'h0010);
    rw(`A_AF, 16'h1000);
    rw(`A_BC, 16'h0002);
    mw(16'h0700, 8'h10);
    rw(`A_HL, 16'h0700);
    go({16'h0000, `OP_CPI, `PFX_EXT}, 8'h00);
    rc(`A_AF, 16'hFFD6, 16'h1046);
    rc(`A_HL, full, 16'h0701);
    rw(`A_HL, 16'h0700);
    mw(16'h0700, 8'h01);
    go({16'h0000, `OP_CPD, `PFX_EXT}, 8'h00);
    rc(`A_AF, 16'hFFD6, 16'h1012);
    rc(`A_HL, full, 16'h06FF);
    $display("test block done");
  endtask : t_block
  task t_repeat;
    int p0;
    rw(`A_BC, 16'h0003);
    rw(`A_HL, 16'h0800);
    rw(`A_DE, 16'h0900);
    mw(16'h0800, 8'h11);
    mw(16'h0801, 8'h22);
    mw(16'h0802, 8'h33);
    mw(16'h0902, 8'h00);
    p0 = pulses;
    go({16'h0000, `OP_BLOCK_MOVE_UP_REPEAT, `PFX_EXT}, 8'h00);
    rc(`A_MDAT, full, 16'h0033);
    rc(`A_BC, full, 16'h0000);
    rc(`A_DE, full, 16'h0903);
    rc(`A_AF, 16'h0004, 16'h0000);
    chk(32'(pulses - p0), 32'h0000_0003);
    rw(`A_BC, 16'h0002);
    rw(`A_HL, 16'h0801);
    rw(`A_DE, 16'h0A01);
    mw(16'h0A00, 8'h00);
    go({16'h0000, `OP_BLOCK_MOVE_DOWN_REPEAT, `PFX_EXT}, 8'h00);
    rc(`A_MDAT, full, 16'h0011);
    rc(`A_HL, full, 16'h07FF);
    rw(`A_AF, 16'h2200);
    rw(`A_HL, 16'h0800);
    rw(`A_BC, 16'h0004);
    p0 = pulses;
    go({16'h0000, `OP_BLOCK_COMPARE_UP_REPEAT, `PFX_EXT}, 8'h00);
    rc(`A_BC, full, 16'h0002);
    rc(`A_AF, 16'h0044, 16'h0044);
    chk(32'(pulses - p0), 32'h0000_0002);
    $display("test repeat done");
  endtask : t_repeat
  task t_err;
    logic [31:0] q;
    logic        e;
    i_apb_host.xfer(1'b0, 8'h38, 32'h0000_0000, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    go({16'h0000, 8'h00, `PFX_EXT}, 8'h00);
    rd(`A_STAT, q);
    chk({31'h0000_0000, q[1]}, 32'h0000_0001);
    $display("test refusal done");
  endtask : t_err
  // ==========================================================
  // verdict, sequence and watchdog
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_shift;
    t_index;
    t_exch;
    t_block;
    t_repeat;
    t_err;
    give_verdict;
  end
  // whole run needs well under 20k cycles
  initial begin
    #1_500_000;
    err_count++;
    give_verdict;
  end
endmodule : memory_shift_exchange_block_ops_bench
